// ===== hw/asrv_regs.svh
// Register offsets, field positions and constants of the sector command block
`ifndef ASRV_REGS_SVH
`define ASRV_REGS_SVH
`define ASRV_OFF_DATA 4'h0
`define ASRV_OFF_FEAT_ERR 4'h1
`define ASRV_OFF_CNT 4'h2
`define ASRV_OFF_LO 4'h3
`define ASRV_OFF_MID 4'h4
`define ASRV_OFF_HI 4'h5
`define ASRV_OFF_DEV 4'h6
`define ASRV_OFF_CMD_ST 4'h7
`define ASRV_OFF_CTRL 4'h8
`define ASRV_OFF_INT_ST 4'h9
`define ASRV_OFF_INT_MASK 4'hA
`define ASRV_OP_READ_EXT 8'h24
`define ASRV_OP_VERIFY 7'h20
`define ASRV_OP_READ 7'h10
`define ASRV_ERR_UNC 6
`define ASRV_ERR_IDN 4
`define ASRV_ERR_ABT 2
`define ASRV_ERR_ZERO_MASK 8'hAB
`define ASRV_ST_BSY 7
`define ASRV_ST_RDY 6
`define ASRV_ST_DSC 4
`define ASRV_ST_DRQ 3
`define ASRV_ST_ERR 0
`define ASRV_DEV_LBA 6
`define ASRV_CTRL_HOB 7
`define ASRV_INT_DONE 0
`define ASRV_INT_DRQ 1
`define ASRV_INT_ERR 2
`define ASRV_CNT28_ZERO 17'h00100
`define ASRV_CNT48_ZERO 17'h10000
`endif

// ===== hw/asrv_pkg.sv
// Types shared by the sector command block
package asrv_pkg;
	typedef enum logic [2:0] {ASRV_IDLE = 3'b001, ASRV_FETCH = 3'b010, ASRV_XFER = 3'b100}
		asrv_fsm_t;
	typedef struct packed {
		asrv_fsm_t fsm;
		logic [7:0] cnt_c;
		logic [7:0] cnt_p;
		logic [7:0] lo_c;
		logic [7:0] lo_p;
		logic [7:0] mid_c;
		logic [7:0] mid_p;
		logic [7:0] hi_c;
		logic [7:0] hi_p;
		logic [7:0] dev;
		logic [7:0] err;
		logic hob;
		logic ext;
		logic xfer;
		logic lba;
		logic drq;
		logic bsy;
		logic errst;
		logic mreq;
		logic [16:0] remain;
		logic [47:0] addr;
		logic [15:0] widx;
		logic [15:0] rdata;
		logic [2:0] ist;
		logic [2:0] imask;
	} asrv_state_t;
endpackage

// ===== hw/asrv_addr_step.sv
// Next sector address in LBA or CHS layout
`timescale 1ns/10ps
module asrv_addr_step
	import asrv_pkg::*;
#(
	parameter logic [7:0] SPT = 8'h3F,
	parameter logic [3:0] HEAD_MAX = 4'hF
)
(
	input wire logic [47:0] cur,
	input wire logic chs,
	output logic [47:0] nxt
);
	logic [7:0] sec;
	logic [3:0] head;
	logic [15:0] cyl;
	always_comb
	begin
		sec = cur[7:0];
		cyl = cur[23:8];
		head = cur[27:24];
		if (!chs)
			nxt = cur + 48'h1;
		else
		begin
			// Sectors count from one, heads and cylinders from zero
			if (sec >= SPT)
			begin
				sec = 8'h01;
				if (head >= HEAD_MAX)
				begin
					head = 4'h0;
					cyl = cyl + 16'h0001;
				end
				else
					head = head + 4'h1;
			end
			else
				sec = sec + 8'h01;
			nxt = {20'h00000, head, cyl, sec};
		end
	end
endmodule

// ===== hw/asrv_sector_buf.sv
// One-sector buffer filled by the media side and drained by the data port
`timescale 1ns/10ps
module asrv_sector_buf
	import asrv_pkg::*;
#(
	parameter int WORDS = 256,
	parameter int AW = $clog2(WORDS)
)
(
	input wire logic clk,
	input wire logic rst,
	input wire logic clr,
	input wire logic wr_en,
	input wire logic [15:0] wr_data,
	input wire logic [AW-1:0] rd_idx,
	output logic [15:0] rd_data
);
	logic [15:0] mem [WORDS];
	logic [AW-1:0] wp_q;
	// Extra words past the sector wrap over the first ones
	always_ff @(posedge clk)
	begin
		if (rst || clr)
			wp_q <= '0;
		else if (wr_en)
			wp_q <= wp_q + AW'(1);
	end
	always_ff @(posedge clk)
	begin
		if (wr_en)
			mem[wp_q] <= wr_data;
	end
	assign rd_data = mem[rd_idx];
endmodule

// ===== hw/asrv_sector_cmd.sv
// Sector read, extended read and read verify command engine
// How it works
// - Opcode 24h reads 1 to 65,536 sectors and hands their data to the host.
// - Sector data leaves through the data port as 16-bit words, one per read.
// - An uncorrectable sector ends the extended read there, later sectors not moved.
// - Extended count is previous:current bytes, zero means 65,536; LBA split over six bytes.
// - After an extended read error the six LBA bytes hold the failing address.
// - Verify opcodes 40h/41h check sectors and move no data to the host.
// - A verify count of zero asks for 256 sectors.
// - An uncorrectable sector ends the verify at that sector.
// - Verify returns unverified sectors in the count register, zero unless an error.
// - Device bit 6 picks CHS or Address_byte_low, mid, high and head carry the address.
// - The lowest opcode bit of verify is ignored, 40h and 41h act alike.
// - Verify leaves the last processed sector address in the address registers.
// - Only UNC, IDN and ABT may be set in error; status bits as tabled.
// - Verify opcode and device fields sit where the host puts them.
// - Verify follows the plain read in addressing, counting and errors, minus data.
// - Plain read count zero means 256; residual unread count is returned.
`timescale 1ns/10ps
`include "asrv_regs.svh"
module asrv_sector_cmd
	import asrv_pkg::*;
#(
	parameter int WORDS = 256,
	parameter logic [7:0] SPT = 8'h3F,
	parameter logic [3:0] HEAD_MAX = 4'hF
)
(
	input wire logic clk,
	input wire logic rst,
	input wire logic [3:0] addr,
	input wire logic [15:0] wdata,
	input wire logic wr,
	input wire logic rd,
	output logic [15:0] rdata,
	output logic media_req,
	output logic [47:0] media_addr,
	output logic media_chs,
	input wire logic media_wvalid,
	input wire logic [15:0] media_wdata,
	input wire logic media_done,
	input wire logic media_unc,
	input wire logic media_idnf,
	output logic irq
);
	localparam int AW = $clog2(WORDS);
	localparam asrv_state_t RST_VAL = '{fsm: ASRV_IDLE, default: '0};
	asrv_state_t q, d;
	logic [47:0] nxt_addr;
	logic [15:0] buf_word;
	logic [7:0] st_v;
	logic [2:0] ev;
	logic [2:0] clr;
	logic cmd_wr;
	logic tf_wr;
	logic sec_ok;
	logic sec_bad;
	logic fin;
	logic is_ext;
	logic is_ver;
	logic is_rd;

	asrv_addr_step #(.SPT(SPT), .HEAD_MAX(HEAD_MAX)) u_step
	(
		.cur(q.addr),
		.chs(!q.lba),
		.nxt(nxt_addr)
	);

	// Verify streams are dropped, so after a verify the buffer still holds the last read sector
	asrv_sector_buf #(.WORDS(WORDS)) u_buf
	(
		.clk(clk),
		.rst(rst),
		.clr(q.mreq),
		.wr_en(media_wvalid && q.xfer && q.fsm == ASRV_FETCH),
		.wr_data(media_wdata),
		.rd_idx(q.widx[AW-1:0]),
		.rd_data(buf_word)
	);

	// Task-file writes are refused while a command owns the registers
	assign tf_wr = wr && !q.bsy && !q.drq;
	assign cmd_wr = tf_wr && addr == `ASRV_OFF_CMD_ST;
	assign is_ext = wdata[7:0] == `ASRV_OP_READ_EXT;
	assign is_ver = wdata[7:1] == `ASRV_OP_VERIFY;
	assign is_rd = wdata[7:1] == `ASRV_OP_READ;

	always_comb
	begin
		st_v = 8'h00;
		// Busy hides while a sector waits, else the host could never fetch it
		st_v[`ASRV_ST_BSY] = q.bsy && !q.drq;
		st_v[`ASRV_ST_RDY] = !q.bsy || q.drq;
		st_v[`ASRV_ST_DSC] = 1'b1;
		st_v[`ASRV_ST_DRQ] = q.drq;
		st_v[`ASRV_ST_ERR] = q.errst;
	end

	always_comb
	begin
		d = q;
		d.mreq = 1'b0;
		d.rdata = 16'h0000;
		ev = 3'b000;
		clr = 3'b000;
		sec_ok = 1'b0;
		sec_bad = 1'b0;
		fin = 1'b0;
		if (rd)
		begin
			unique case (addr)
				`ASRV_OFF_DATA: d.rdata = q.drq ? buf_word : 16'h0000;
				`ASRV_OFF_FEAT_ERR: d.rdata = {8'h00, q.err};
				`ASRV_OFF_CNT: d.rdata = {8'h00, q.hob ? q.cnt_p : q.cnt_c};
				`ASRV_OFF_LO: d.rdata = {8'h00, q.hob ? q.lo_p : q.lo_c};
				`ASRV_OFF_MID: d.rdata = {8'h00, q.hob ? q.mid_p : q.mid_c};
				`ASRV_OFF_HI: d.rdata = {8'h00, q.hob ? q.hi_p : q.hi_c};
				`ASRV_OFF_DEV: d.rdata = {8'h00, q.dev};
				`ASRV_OFF_CMD_ST: d.rdata = {8'h00, st_v};
				`ASRV_OFF_CTRL: d.rdata = {8'h00, q.hob, 7'h00};
				`ASRV_OFF_INT_ST:
				begin
					d.rdata = {13'h0000, q.ist};
					clr = 3'b111;
				end
				`ASRV_OFF_INT_MASK: d.rdata = {13'h0000, q.imask};
				default: d.rdata = 16'h0000;
			endcase
		end
		if (wr && addr == `ASRV_OFF_CTRL)
			d.hob = wdata[`ASRV_CTRL_HOB];
		if (wr && addr == `ASRV_OFF_INT_MASK)
			d.imask = wdata[2:0];
		// The count and three address bytes keep their previous values for the 48-bit forms
		if (tf_wr)
		begin
			unique case (addr)
				`ASRV_OFF_CNT:
				begin
					d.cnt_p = q.cnt_c;
					d.cnt_c = wdata[7:0];
				end
				`ASRV_OFF_LO:
				begin
					d.lo_p = q.lo_c;
					d.lo_c = wdata[7:0];
				end
				`ASRV_OFF_MID:
				begin
					d.mid_p = q.mid_c;
					d.mid_c = wdata[7:0];
				end
				`ASRV_OFF_HI:
				begin
					d.hi_p = q.hi_c;
					d.hi_c = wdata[7:0];
				end
				`ASRV_OFF_DEV: d.dev = wdata[7:0];
				default: ;
			endcase
		end
		if (cmd_wr)
		begin
			d.err = 8'h00;
			d.errst = 1'b0;
			if (is_ext || is_ver || is_rd)
			begin
				d.ext = is_ext;
				d.xfer = !is_ver;
				d.lba = is_ext || q.dev[`ASRV_DEV_LBA];
				if (is_ext)
				begin
					d.remain = {1'b0, q.cnt_p, q.cnt_c};
					if (q.cnt_p == 8'h00 && q.cnt_c == 8'h00)
						d.remain = `ASRV_CNT48_ZERO;
					d.addr = {q.hi_p, q.mid_p, q.lo_p, q.hi_c, q.mid_c, q.lo_c};
				end
				else
				begin
					d.remain = {9'h000, q.cnt_c};
					if (q.cnt_c == 8'h00)
						d.remain = `ASRV_CNT28_ZERO;
					d.addr = {20'h00000, q.dev[3:0], q.hi_c, q.mid_c, q.lo_c};
				end
				d.bsy = 1'b1;
				d.mreq = 1'b1;
				d.fsm = ASRV_FETCH;
			end
			else
			begin
				d.err[`ASRV_ERR_ABT] = 1'b1;
				d.errst = 1'b1;
				ev[`ASRV_INT_DONE] = 1'b1;
				ev[`ASRV_INT_ERR] = 1'b1;
			end
		end
		unique case (q.fsm)
			ASRV_IDLE: ;
			ASRV_FETCH:
			begin
				if (media_done)
				begin
					if (media_unc || media_idnf)
						sec_bad = 1'b1;
					else if (q.xfer)
					begin
						d.drq = 1'b1;
						d.widx = 16'h0000;
						d.fsm = ASRV_XFER;
						ev[`ASRV_INT_DRQ] = 1'b1;
					end
					else
						sec_ok = 1'b1;
				end
			end
			ASRV_XFER:
			begin
				// Host reads only after data request is up
				if (rd && addr == `ASRV_OFF_DATA)
				begin
					d.widx = q.widx + 16'h0001;
					if (q.widx == 16'(WORDS - 1))
					begin
						d.drq = 1'b0;
						sec_ok = 1'b1;
					end
				end
			end
		endcase
		if (sec_ok)
		begin
			d.remain = q.remain - 17'h00001;
			if (q.remain == 17'h00001)
				fin = 1'b1;
			else
			begin
				d.addr = nxt_addr;
				d.mreq = 1'b1;
				d.fsm = ASRV_FETCH;
			end
		end
		if (sec_bad)
		begin
			// Failing sector stays counted as not done
			fin = 1'b1;
			d.err[`ASRV_ERR_UNC] = media_unc;
			d.err[`ASRV_ERR_IDN] = media_idnf;
			d.errst = 1'b1;
			ev[`ASRV_INT_ERR] = 1'b1;
		end
		if (fin)
		begin
			d.fsm = ASRV_IDLE;
			d.bsy = 1'b0;
			d.drq = 1'b0;
			d.cnt_c = d.remain[7:0];
			d.lo_c = q.addr[7:0];
			d.mid_c = q.addr[15:8];
			d.hi_c = q.addr[23:16];
			if (q.ext)
			begin
				d.cnt_p = d.remain[15:8];
				d.lo_p = q.addr[31:24];
				d.mid_p = q.addr[39:32];
				d.hi_p = q.addr[47:40];
			end
			else
				d.dev[3:0] = q.addr[27:24];
			ev[`ASRV_INT_DONE] = 1'b1;
		end
		// A new event beats the read that clears it
		d.ist = (q.ist & ~clr) | ev;
	end

	always_ff @(posedge clk)
	begin
		if (rst)
			q <= RST_VAL;
		else
			q <= d;
	end

	assign rdata = q.rdata;
	assign media_req = q.mreq;
	assign media_addr = q.addr;
	assign media_chs = !q.lba;
	assign irq = |(q.ist & q.imask);

	default clocking cb @(posedge clk);
	endclocking
	default disable iff (rst);

	property p_media_busy;
		q.mreq |-> (q.bsy && q.fsm == ASRV_FETCH && !q.drq);
	endproperty
	a_media_busy: assert property (p_media_busy) else $error("media request while idle");

	property p_last_word;
		(q.fsm == ASRV_XFER && rd && addr == `ASRV_OFF_DATA && q.widx == 16'(WORDS - 1))
			|=> !q.drq;
	endproperty
	a_last_word: assert property (p_last_word) else $error("data request after last word");

	property p_unc_stop;
		(q.fsm == ASRV_FETCH && media_done && media_unc)
			|=> (q.fsm == ASRV_IDLE && !q.drq && !q.bsy && q.err[`ASRV_ERR_UNC] && q.errst);
	endproperty
	a_unc_stop: assert property (p_unc_stop) else $error("command ran past bad sector");

	property p_ext_zero;
		(cmd_wr && is_ext && q.cnt_c == 8'h00 && q.cnt_p == 8'h00)
			|=> q.remain == `ASRV_CNT48_ZERO;
	endproperty
	a_ext_zero: assert property (p_ext_zero) else $error("zero extended count wrong");

	property p_fail_addr;
		(q.fsm == ASRV_FETCH && media_done && (media_unc || media_idnf) && q.ext)
			|=> {q.hi_p, q.mid_p, q.lo_p, q.hi_c, q.mid_c, q.lo_c} == $past(q.addr);
	endproperty
	a_fail_addr: assert property (p_fail_addr) else $error("failing address not kept");

	property p_verify_no_data;
		(q.bsy && !q.xfer) |-> (!q.drq && q.fsm != ASRV_XFER);
	endproperty
	a_verify_no_data: assert property (p_verify_no_data) else $error("verify raised data");

	property p_verify_zero;
		(cmd_wr && is_ver && q.cnt_c == 8'h00) |=> q.remain == `ASRV_CNT28_ZERO;
	endproperty
	a_verify_zero: assert property (p_verify_zero) else $error("zero verify count wrong");

	property p_residual;
		(q.fsm == ASRV_FETCH && media_done && !media_unc && !media_idnf && !q.xfer
			&& q.remain == 17'h00001) |=> (q.cnt_c == 8'h00 && !q.bsy && !q.errst);
	endproperty
	a_residual: assert property (p_residual) else $error("verify residual not zero");

	property p_retry_ignored;
		(cmd_wr && is_ver) |=> (q.bsy && !q.xfer && !q.ext) ##1 q.bsy;
	endproperty
	a_retry_ignored: assert property (p_retry_ignored) else $error("verify opcode misread");

	property p_err_bits;
		(q.err & `ASRV_ERR_ZERO_MASK) == 8'h00;
	endproperty
	a_err_bits: assert property (p_err_bits) else $error("reserved error bit set");

	cover property (q.ext && q.drq ##1 !q.bsy);
	cover property (q.fsm == ASRV_FETCH && media_done && media_unc && !q.xfer);
	cover property (cmd_wr && !is_ext && !is_ver && !is_rd);
endmodule

// ===== tb/asrv_media_model.sv
// Media side stand-in: sector words, completion and injected faults
`timescale 1ns/10ps
module asrv_media_model #(
	parameter int WORDS = 4
)
(
	input wire logic clk,
	input wire logic rst,
	input wire logic media_req,
	input wire logic [47:0] media_addr,
	input wire logic slow,
	input wire logic fail_en,
	input wire logic fail_idnf,
	input wire logic [47:0] fail_lba,
	output logic media_wvalid,
	output logic [15:0] media_wdata,
	output logic media_done,
	output logic media_unc,
	output logic media_idnf
);
	logic [47:0] a;
	logic hit;
	initial
		{media_wvalid, media_wdata, media_done, media_unc, media_idnf} = '0;
	always @(posedge clk)
	begin
		// Idle data is inverted every cycle, but holds the last word for two cycles after it
		media_wdata <= ~media_wdata;
		if (!rst && media_req)
		begin
			a = media_addr;
			hit = fail_en && a == fail_lba;
			repeat (slow ? 6 : 1) @(posedge clk);
			for (int i = 0; i < WORDS; i++)
			begin
				media_wvalid <= 1'b1;
				media_wdata <= a[15:0] ^ {8'(i), 8'hA5};
				@(posedge clk);
			end
			media_wvalid <= 1'b0;
			media_done <= 1'b1;
			media_unc <= hit && !fail_idnf;
			media_idnf <= hit && fail_idnf;
			@(posedge clk);
			media_done <= 1'b0;
		end
	end
endmodule

// ===== tb/asrv_sector_cmd_tb.sv
// Self-checking bench for the sector command engine
`timescale 1ns/10ps
`include "asrv_regs.svh"
module asrv_sector_cmd_tb;
	localparam int WORDS = 4;
	logic clk, rst, wr, rd, req, chs, irq, wv, dn, unc, idnf, slow, f_en, f_id;
	logic [3:0] addr;
	logic [15:0] wdata, rdata, wd, v;
	logic [47:0] maddr, f_lba, m0, eb, vb;
	int bad_count = 0, checks_done = 0, nreq = 0, cyc = 0;
	asrv_sector_cmd #(.WORDS(WORDS)) uut (.clk(clk), .rst(rst), .addr(addr), .wdata(wdata),
		.wr(wr), .rd(rd), .rdata(rdata), .media_req(req), .media_addr(maddr), .media_chs(chs),
		.media_wvalid(wv), .media_wdata(wd), .media_done(dn), .media_unc(unc),
		.media_idnf(idnf), .irq(irq));
	asrv_media_model #(.WORDS(WORDS)) media (.clk(clk), .rst(rst), .media_req(req),
		.media_addr(maddr), .slow(slow), .fail_en(f_en), .fail_idnf(f_id), .fail_lba(f_lba),
		.media_wvalid(wv), .media_wdata(wd), .media_done(dn), .media_unc(unc), .media_idnf(idnf));
	initial
	begin
		clk = 0;
		forever #25 clk = ~clk;
	end
	always @(posedge clk)
	begin
		cyc++;
		if (req)
		begin
			nreq++;
			m0 <= maddr;
		end
		if (cyc == 40000)
		begin
			bad_count++;
			final_report();
		end
	end
	task final_report();
		$display("checks %0d mismatches %0d", checks_done, bad_count);
		if (bad_count == 0 && checks_done > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	task chk(input logic [47:0] g, input logic [47:0] e);
		checks_done++;
		if (g !== e)
		begin
			bad_count++;
			$display("unexpected at %0t: got %h want %h", $time, g, e);
		end
	endtask
	task wreg(input logic [3:0] a, input logic [15:0] d);
		@(posedge clk);
		wr <= 1'b1;
		addr <= a;
		wdata <= d;
		@(posedge clk);
		wr <= 1'b0;
	endtask
	task rreg(input logic [3:0] a);
		@(posedge clk);
		rd <= 1'b1;
		addr <= a;
		@(posedge clk);
		rd <= 1'b0;
		#1 v = rdata;
	endtask
	function automatic logic [15:0] word_of(input logic [47:0] a, input int i);
		return a[15:0] ^ {8'(i), 8'hA5};
	endfunction
	task rc(input logic [3:0] a, input logic [15:0] e);
		rreg(a);
		chk(48'(v), 48'(e));
	endtask
	task poll();
		rreg(`ASRV_OFF_CMD_ST);
		for (int n = 0; n < 3000 && v[7] !== 1'b0; n++)
			rreg(`ASRV_OFF_CMD_ST);
	endtask
	// High-order byte first, so it ends up in the previous slot
	task cmd(input logic [15:0] c, input logic [47:0] a, input logic [7:0] dev, input logic [7:0] op);
		for (int k = 0; k < 2; k++)
		begin
			wreg(`ASRV_OFF_CNT, 16'(c[8*(1-k) +: 8]));
			wreg(`ASRV_OFF_LO, 16'(a[24*(1-k) +: 8]));
			wreg(`ASRV_OFF_MID, 16'(a[24*(1-k)+8 +: 8]));
			wreg(`ASRV_OFF_HI, 16'(a[24*(1-k)+16 +: 8]));
		end
		wreg(`ASRV_OFF_DEV, 16'(dev));
		wreg(`ASRV_OFF_CMD_ST, 16'(op));
	endtask
	task ext(input logic [7:0] op, input int cnt, input logic [47:0] a, input int bad);
		f_lba <= a + 48'(bad);
		f_en <= bad < cnt;
		cmd(16'(cnt), a, {4'h4, a[27:24]}, op);
		for (int s = 0; s < bad && s < cnt; s++)
		begin
			poll();
			chk(48'(v), 48'h58);
			for (int i = 0; i < WORDS; i++)
			begin
				rreg(`ASRV_OFF_DATA);
				chk(48'(v), 48'(word_of(a + 48'(s), i)));
			end
		end
		poll();
		chk(48'(v), bad < cnt ? 48'h51 : 48'h50);
		rc(`ASRV_OFF_FEAT_ERR, bad < cnt ? 16'h40 : 16'h0);
		rc(`ASRV_OFF_DATA, 16'h0);
		rc(`ASRV_OFF_CNT, 16'((bad < cnt ? cnt - bad : 0) % 256));
	endtask
	task ver(input logic [7:0] op, input int cnt, input logic [47:0] a, input int bad);
		int tot, r0;
		logic [47:0] l;
		tot = cnt == 0 ? 256 : cnt;
		l = a + 48'(bad < tot ? bad : tot - 1);
		f_lba <= a + 48'(bad);
		f_en <= bad < tot;
		rreg(`ASRV_OFF_INT_ST);
		r0 = nreq;
		cmd(16'(cnt), a, {4'h4, a[27:24]}, op);
		poll();
		chk(48'(v), bad < tot ? 48'h51 : 48'h50);
		chk(48'(nreq - r0), 48'(bad < tot ? bad + 1 : tot));
		rc(`ASRV_OFF_FEAT_ERR, bad >= tot ? 16'h0 : f_id ? 16'h10 : 16'h40);
		rc(`ASRV_OFF_CNT, 16'(bad < tot ? tot - bad : 0));
		for (int k = 0; k < 3; k++)
			rc(4'(`ASRV_OFF_LO + k), 16'(l[8*k +: 8]));
		rc(`ASRV_OFF_INT_ST, bad < tot ? 16'h5 : 16'h1);
	endtask
	initial
	begin
		{wr, rd, addr, wdata, f_en, f_id, slow, f_lba} = '0;
		rst = 1'b1;
		void'($urandom(32'h9CC1));
		repeat (3) @(posedge clk);
		rst <= 1'b0;
		rc(`ASRV_OFF_CMD_ST, 16'h50);
		rc(4'hB, 16'h0);
		wreg(`ASRV_OFF_CMD_ST, 16'hEC);
		rc(`ASRV_OFF_FEAT_ERR, 16'h4);
		eb = 48'({$urandom(), $urandom()}) & ~48'hFF;
		ext(`ASRV_OP_READ_EXT, 3, eb, 3);
		wreg(`ASRV_OFF_INT_MASK, 16'h7);
		rreg(`ASRV_OFF_INT_ST);
		ext(`ASRV_OP_READ_EXT, 3, eb, 1);
		chk(48'(irq), 48'h1);
		rc(`ASRV_OFF_INT_ST, 16'h7);
		chk(48'(irq), 48'h0);
		for (int h = 0; h < 2; h++)
		begin
			wreg(`ASRV_OFF_CTRL, 16'(h << 7));
			for (int k = 0; k < 3; k++)
				rc(4'(`ASRV_OFF_LO + k), 16'(f_lba[24*h + 8*k +: 8]));
		end
		wreg(`ASRV_OFF_CTRL, 16'h0);
		wreg(`ASRV_OFF_INT_MASK, 16'h0);
		slow <= 1'b1;
		ext(`ASRV_OP_READ_EXT, 256, eb, 256);
		vb = 48'($urandom()) & 48'hFFFFF00;
		ext(`ASRV_OP_READ_EXT, 65536, eb, 0);
		ext(8'h21, 256, vb, 1);
		for (int j = 0; j < 4; j++)
		begin
			slow <= j[0];
			f_id <= j[1];
			ver(8'h40 | 8'(j & 1), 1 + $urandom_range(0, 4), vb, $urandom_range(0, 5));
		end
		ver(8'h41, 0, vb, 256);
		f_en <= 1'b0;
		cmd(16'h2, 48'h12_343F, 8'h03, 8'h40);
		poll();
		chk(m0, 48'h412_3401);
		chk(48'(chs), 48'h1);
		rc(`ASRV_OFF_LO, 16'h01);
		rc(`ASRV_OFF_MID, 16'h34);
		rc(`ASRV_OFF_DEV, 16'h04);
		chk(48'(irq), 48'h0);
		final_report();
	end
endmodule
